// [pkg/spi_port_pkg.sv]
// shared constants, types and behaviour summary for the serial port
// How it works
// - bytes move msb first on one clock
// - master starts; slave answers simultaneously on miso
// - both ends share polarity and phase setting
// - soft manage replaces pin with soft level
// - phase-zero slave writes with select low collide
// - master sck from six rates, fastest quarter
// - master and enable hold only while select high
// - master data write loads and starts shifting
// - slave data write loads shift register
// - slave shifts only on master clock edges
// - byte end sets done flag, maybe interrupt
// - master clears done: status access, data read
// - slave clears done: status access, data access
// - data writes ignored while done flag pending, until status read
// - single master only, no multi-master arbitration
// - select low as master: fault, drop to slave
// - write during transfer discarded, collision flag set
// - byte before clear sets overrun, keeps buffer
package spi_port_pkg;
    localparam int          SYNC_LAG   = 4;             // pin to clean value latency
    localparam int          RATE_COUNT = 6;             // number of master rates
    localparam logic [2:0]  RATE_LAST  = 3'h5;          // slowest rate code
    localparam logic [3:0]  LAST_EDGE  = 4'hf;          // sixteenth sck edge
    localparam logic [7:0]  DATA_RESET = 8'h00;         // data buffer after reset
    // sck half periods in cpu cycles, code 0 is cpu/4
    localparam logic [6:0]  HALF_DIV [RATE_COUNT] = '{7'h02, 7'h04, 7'h08,
                                                      7'h10, 7'h20, 7'h40};
    typedef enum logic [1:0] {M_IDLE, M_SHIFT, M_FLUSH} master_state_e;
endpackage

// [pkg/pin_sync_if.sv]
// carrier between the port core and its pin synchroniser
`timescale 1ns/100ps
interface pin_sync_if #(parameter int W = 4);
    logic [W-1:0] raw;      // pin levels as they arrive
    logic [W-1:0] clean;    // filtered levels on sys_clk_in
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

// [verilog/pin_sync.sv]
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 4
) (
    input  wire logic    sys_clk_in,
    input  wire logic    rst_in,
    pin_sync_if.sync     pins
);
    logic [W-1:0] s1;          // first stage, read only by s2
    logic [W-1:0] s2;          // second stage
    logic [W-1:0] s3;          // third stage
    logic [W-1:0] next_clean;  // filtered next value

    // accept a level once stages two and three agree
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_clean[i] = (s2[i] == s3[i]) ? s3[i] : pins.clean[i];
        end
    end

    // register stages and filtered value
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            s1         <= '0;
            s2         <= '0;
            s3         <= '0;
            pins.clean <= '0;
        end else begin
            s1         <= pins.raw;
            s2         <= s1;
            s3         <= s2;
            pins.clean <= next_clean;
        end
    end
endmodule

// [verilog/spi_master_slave_port.sv]
// serial port core: master/slave shifter, select handling, status flags
`timescale 1ns/100ps
module spi_master_slave_port (
    input  wire logic       sys_clk_in,
    input  wire logic       rst_in,
    input  wire logic [2:0] clock_rate_select_in,
    input  wire logic       clock_polarity_in,
    input  wire logic       clock_phase_in,
    input  wire logic       select_soft_manage_in,
    input  wire logic       select_soft_level_in,
    input  wire logic       port_irq_enable_in,
    input  wire logic       cpu_irq_mask_in,
    input  wire logic       csr_read_in,
    input  wire logic       cr_write_in,
    input  wire logic       master_select_wr_in,
    input  wire logic       port_enable_wr_in,
    input  wire logic       dr_write_in,
    input  wire logic [7:0] dr_wdata_in,
    input  wire logic       dr_read_in,
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic       miso_in,
    input  wire logic       ss_n_in,
    output logic            sck_out,
    output logic            sck_oe_out,
    output logic            mosi_out,
    output logic            mosi_oe_out,
    output logic            miso_out,
    output logic            miso_oe_out,
    output logic [7:0]      dr_rdata_out,
    output logic            transfer_done_flag_out,
    output logic            mode_fault_flag_out,
    output logic            write_collision_flag_out,
    output logic            overrun_flag_out,
    output logic            master_select_out,
    output logic            port_enable_out,
    output logic            busy_out,
    output logic            irq_out
);
    localparam int LAG = spi_port_pkg::SYNC_LAG;

    pin_sync_if #(.W(4)) pins ();               // synchronised pins

    spi_port_pkg::master_state_e state;         // master sequencer
    spi_port_pkg::master_state_e next_state;
    logic [6:0]     div_cnt, next_div_cnt;      // half period counter
    logic [3:0]     edge_cnt, next_edge_cnt;    // sck edges in this byte
    logic           sck_prev, next_sck_prev;    // slave edge detect
    logic [LAG-1:0] samp_pipe, next_samp_pipe;  // master sample delay line
    logic [7:0]     tx_sh, next_tx_sh;          // outgoing shift register
    logic [7:0]     rx_sh, next_rx_sh;          // incoming shift register
    logic           out_bit, next_out_bit;      // bit on mosi or miso
    logic           csr_armed, next_csr_armed;  // status read seen, done/coll
    logic           mode_fault_flag_armed, next_mode_fault_flag_armed;// status read seen, fault
    logic           next_sck, next_sck_oe, next_mosi_oe, next_miso_oe;
    logic [7:0]     next_rdata;
    logic           next_done, next_mode_fault_flag, next_write_collision_flag, next_ovr;
    logic           next_ms, next_pe, next_busy, next_irq;

    // combinational helpers
    logic           miso_c, mosi_c, sck_c, ss_c;
    logic           ss_int, slave_on, edge_now, leading, sample_edge, drive_edge;
    logic           in_xfer, wr_ok, done_clr, complete;
    logic [2:0]     rate_idx;
    logic [6:0]     half;

    assign pins.raw = {ss_n_in, sck_in, mosi_in, miso_in};

    pin_sync #(.W(4)) u_sync (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .pins       (pins)
    );

    assign {ss_c, sck_c, mosi_c, miso_c} = pins.clean;

    // next-state logic for the whole port
    always_comb begin
        // internal select from pin or soft level
        ss_int   = select_soft_manage_in ? select_soft_level_in : ss_c;
        slave_on = port_enable_out && !master_select_out && !ss_int;
        rate_idx = (clock_rate_select_in > spi_port_pkg::RATE_LAST)
                   ? spi_port_pkg::RATE_LAST : clock_rate_select_in;
        half     = spi_port_pkg::HALF_DIV[rate_idx];
        // edge classification shared by both modes
        edge_now = master_select_out
                   ? (state == spi_port_pkg::M_SHIFT && div_cnt == half - 7'h01)
                   : (slave_on && sck_c != sck_prev);
        leading     = !edge_cnt[0];
        sample_edge = edge_now && (leading ^ clock_phase_in);
        drive_edge  = edge_now && !(leading ^ clock_phase_in);
        in_xfer     = (state != spi_port_pkg::M_IDLE) || (slave_on && edge_cnt != 4'h0);
        // data writes held off until status read while done pending
        wr_ok    = dr_write_in && (!transfer_done_flag_out || csr_armed);
        done_clr = csr_armed && transfer_done_flag_out &&
                   (dr_read_in || (!master_select_out && dr_write_in));

        // defaults
        next_state      = state;
        next_div_cnt    = div_cnt;
        next_edge_cnt   = edge_cnt;
        next_sck_prev   = sck_c;
        next_samp_pipe  = {samp_pipe[LAG-2:0], sample_edge && master_select_out};
        next_tx_sh      = tx_sh;
        next_rx_sh      = rx_sh;
        next_out_bit    = out_bit;
        next_sck        = sck_out;
        next_rdata      = dr_rdata_out;
        next_done       = transfer_done_flag_out;
        next_mode_fault_flag       = mode_fault_flag_out;
        next_write_collision_flag       = write_collision_flag_out;
        next_ovr        = overrun_flag_out;
        next_ms         = master_select_out;
        next_pe         = port_enable_out;
        next_csr_armed  = csr_armed;
        next_mode_fault_flag_armed = mode_fault_flag_armed;
        complete        = 1'b0;

        // status read arms the clearing sequences; overrun clears at once
        if (csr_read_in) begin
            if (transfer_done_flag_out || write_collision_flag_out) begin
                next_csr_armed = 1'b1;
            end
            if (mode_fault_flag_out) begin
                next_mode_fault_flag_armed = 1'b1;
            end
            next_ovr = 1'b0;
        end
        if (dr_read_in || dr_write_in) begin
            next_csr_armed = 1'b0;
            if (csr_armed && dr_read_in) begin
                next_write_collision_flag = 1'b0;
            end
        end
        if (done_clr) begin
            next_done = 1'b0;
        end

        // control write; fault blocks setting outside its clear sequence
        if (cr_write_in) begin
            if (mode_fault_flag_out && !mode_fault_flag_armed) begin
                next_ms = 1'b0;
                next_pe = 1'b0;
            end else begin
                next_ms   = master_select_wr_in;
                next_pe   = port_enable_wr_in;
                next_mode_fault_flag = 1'b0;
            end
            next_mode_fault_flag_armed = 1'b0;
        end

        // shifting: sample in, drive out, msb first
        if (sample_edge && !master_select_out) begin
            next_rx_sh = {rx_sh[6:0], mosi_c};
        end
        if (samp_pipe[LAG-1]) begin
            next_rx_sh = {rx_sh[6:0], miso_c};
        end
        if (drive_edge) begin
            next_out_bit = clock_phase_in ? tx_sh[7] : tx_sh[6];
            next_tx_sh   = {tx_sh[6:0], 1'b0};
        end

        // master sequencer
        case (state)
            spi_port_pkg::M_IDLE: begin
                next_sck = clock_polarity_in;
            end
            spi_port_pkg::M_SHIFT: begin
                next_div_cnt = div_cnt + 7'h01;
                if (edge_now) begin
                    next_div_cnt  = 7'h00;
                    next_sck      = !sck_out;
                    next_edge_cnt = edge_cnt + 4'h1;
                    if (edge_cnt == spi_port_pkg::LAST_EDGE) begin
                        next_state = spi_port_pkg::M_FLUSH;
                    end
                end
            end
            spi_port_pkg::M_FLUSH: begin
                // wait for the last delayed sample to land
                if (samp_pipe == '0) begin
                    complete   = 1'b1;
                    next_state = spi_port_pkg::M_IDLE;
                end
            end
            default: begin
                next_state = spi_port_pkg::M_IDLE;
            end
        endcase

        // slave edge counting, restarted whenever select rises
        if (!master_select_out) begin
            if (!slave_on) begin
                next_edge_cnt = 4'h0;
            end else if (edge_now) begin
                next_edge_cnt = edge_cnt + 4'h1;
                complete      = (edge_cnt == spi_port_pkg::LAST_EDGE);
            end
        end

        // accepted data write: collide, or load and start
        if (wr_ok) begin
            if (in_xfer || (slave_on && !clock_phase_in)) begin
                next_write_collision_flag = 1'b1;
            end else begin
                next_tx_sh   = dr_wdata_in;
                next_out_bit = dr_wdata_in[7];
                if (master_select_out && port_enable_out) begin
                    next_state    = spi_port_pkg::M_SHIFT;
                    next_div_cnt  = 7'h00;
                    next_edge_cnt = 4'h0;
                end
            end
        end else if (!in_xfer && !drive_edge) begin
            next_out_bit = tx_sh[7];
        end

        // byte end: done flag or overrun keeping the earlier byte
        if (complete) begin
            if (transfer_done_flag_out && !done_clr) begin
                next_ovr = 1'b1;
            end else begin
                next_done      = 1'b1;
                next_rdata     = next_rx_sh;
                next_csr_armed = 1'b0; // fresh byte needs a fresh status read
            end
        end

        // select low while master: fault and fall back to slave
        if (master_select_out && port_enable_out && !ss_int) begin
            next_mode_fault_flag  = 1'b1;
            next_ms    = 1'b0;
            next_pe    = 1'b0;
        end
        if (!next_ms || !next_pe) begin
            next_state     = spi_port_pkg::M_IDLE; // also cancels a start in this cycle
            next_samp_pipe = '0;
        end

        next_sck_oe  = next_ms && next_pe;
        next_mosi_oe = next_ms && next_pe;
        next_miso_oe = !next_ms && next_pe && !ss_int;
        next_busy    = (next_state != spi_port_pkg::M_IDLE) ||
                       (next_edge_cnt != 4'h0);
        next_irq     = port_irq_enable_in && !cpu_irq_mask_in &&
                       (next_done || next_mode_fault_flag || next_ovr);
    end

    // register every piece of state and every output
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state                    <= spi_port_pkg::M_IDLE;
            div_cnt                  <= 7'h00;
            edge_cnt                 <= 4'h0;
            sck_prev                 <= 1'b0;
            samp_pipe                <= '0;
            tx_sh                    <= spi_port_pkg::DATA_RESET;
            rx_sh                    <= spi_port_pkg::DATA_RESET;
            out_bit                  <= 1'b0;
            csr_armed                <= 1'b0;
            mode_fault_flag_armed               <= 1'b0;
            sck_out                  <= 1'b0;
            sck_oe_out               <= 1'b0;
            mosi_out                 <= 1'b0;
            mosi_oe_out              <= 1'b0;
            miso_out                 <= 1'b0;
            miso_oe_out              <= 1'b0;
            dr_rdata_out             <= spi_port_pkg::DATA_RESET;
            transfer_done_flag_out   <= 1'b0;
            mode_fault_flag_out      <= 1'b0;
            write_collision_flag_out <= 1'b0;
            overrun_flag_out         <= 1'b0;
            master_select_out        <= 1'b0;
            port_enable_out          <= 1'b0;
            busy_out                 <= 1'b0;
            irq_out                  <= 1'b0;
        end else begin
            state                    <= next_state;
            div_cnt                  <= next_div_cnt;
            edge_cnt                 <= next_edge_cnt;
            sck_prev                 <= next_sck_prev;
            samp_pipe                <= next_samp_pipe;
            tx_sh                    <= next_tx_sh;
            rx_sh                    <= next_rx_sh;
            out_bit                  <= next_out_bit;
            csr_armed                <= next_csr_armed;
            mode_fault_flag_armed               <= next_mode_fault_flag_armed;
            sck_out                  <= next_sck;
            sck_oe_out               <= next_sck_oe;
            mosi_out                 <= next_out_bit;
            mosi_oe_out              <= next_mosi_oe;
            miso_out                 <= next_out_bit;
            miso_oe_out              <= next_miso_oe;
            dr_rdata_out             <= next_rdata;
            transfer_done_flag_out   <= next_done;
            mode_fault_flag_out      <= next_mode_fault_flag;
            write_collision_flag_out <= next_write_collision_flag;
            overrun_flag_out         <= next_ovr;
            master_select_out        <= next_ms;
            port_enable_out          <= next_pe;
            busy_out                 <= next_busy;
            irq_out                  <= next_irq;
        end
    end
endmodule

// [testbench/spi_master_slave_port_asserts.sv]
// concurrent checks on the serial port core, bound to its ports
`timescale 1ns/100ps
module spi_master_slave_port_asserts (
    input wire logic       sys_clk_in,
    input wire logic       rst_in,
    input wire logic       clock_polarity_in,
    input wire logic       clock_phase_in,
    input wire logic       select_soft_manage_in,
    input wire logic       select_soft_level_in,
    input wire logic       port_irq_enable_in,
    input wire logic       cpu_irq_mask_in,
    input wire logic       csr_read_in,
    input wire logic       dr_write_in,
    input wire logic [7:0] dr_wdata_in,
    input wire logic       dr_read_in,
    input wire logic       sck_out,
    input wire logic       sck_oe_out,
    input wire logic       mosi_out,
    input wire logic       mosi_oe_out,
    input wire logic       transfer_done_flag_out,
    input wire logic       mode_fault_flag_out,
    input wire logic       write_collision_flag_out,
    input wire logic       overrun_flag_out,
    input wire logic       master_select_out,
    input wire logic       port_enable_out,
    input wire logic       busy_out,
    input wire logic       irq_out
);
    logic armed;      // status read seen while done is up
    logic next_armed; // next value of armed
    logic msb;        // top bit of the written byte
    assign msb = dr_wdata_in[7];
    // arming drops on any data access or while done is low
    always_comb begin
        next_armed = transfer_done_flag_out && !dr_read_in && !dr_write_in
                     && (armed || csr_read_in);
    end
    always_ff @(posedge sys_clk_in) begin
        armed <= rst_in ? 1'b0 : next_armed;
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_flt; master_select_out && port_enable_out && select_soft_manage_in
        && !select_soft_level_in |-> ##[1:2] (mode_fault_flag_out && !master_select_out);
    endproperty
    a_flt: assert property (p_flt) else $error("mode fault missing");
    property p_idle; master_select_out && sck_oe_out && !busy_out && !$past(busy_out)
        && $stable(clock_polarity_in) |-> sck_out == clock_polarity_in; endproperty
    a_idle: assert property (p_idle) else $error("sck idle level wrong");
    property p_irq; irq_out == ($past(port_irq_enable_in) && !$past(cpu_irq_mask_in)
        && (transfer_done_flag_out || mode_fault_flag_out || overrun_flag_out)); endproperty
    a_irq: assert property (p_irq) else $error("irq level wrong");
    property p_start; dr_write_in && master_select_out && port_enable_out && !busy_out
        && !transfer_done_flag_out && !clock_phase_in
        |=> busy_out && mosi_oe_out && mosi_out == $past(msb); endproperty
    a_start: assert property (p_start) else $error("master start wrong");
    property p_clr; $fell(transfer_done_flag_out)
        |-> $past(armed) && ($past(dr_read_in) || $past(dr_write_in)); endproperty
    a_clr: assert property (p_clr) else $error("done cleared early");
    property p_ign; transfer_done_flag_out && !armed && !csr_read_in && dr_write_in
        && !busy_out |=> !busy_out && $stable(write_collision_flag_out); endproperty
    a_ign: assert property (p_ign) else $error("write not ignored");
    property p_col; dr_write_in && busy_out && !(transfer_done_flag_out && !armed)
        |=> write_collision_flag_out; endproperty
    a_col: assert property (p_col) else $error("collision missing");
    property p_ovr; overrun_flag_out && csr_read_in |=> !overrun_flag_out; endproperty
    a_ovr: assert property (p_ovr) else $error("overrun not cleared");
    property p_oe; !port_enable_out |-> !sck_oe_out && !mosi_oe_out; endproperty
    a_oe: assert property (p_oe) else $error("driving while disabled");
endmodule
bind spi_master_slave_port spi_master_slave_port_asserts chk (.*);

// [testbench/spi_far_slave.sv]
// behavioural far-end slave that answers the port in master mode
`timescale 1ns/100ps
module spi_far_slave (
    input  wire logic       sel_n_in,
    input  wire logic       sck_in,
    input  wire logic       mosi_in,
    input  wire logic       pol_in,
    input  wire logic       pha_in,
    input  wire logic [7:0] tx_in,
    output logic            miso_out,
    output logic [7:0]      rx_out
);
    logic [7:0] sh = 8'h00;  // bits still to send
    logic       bq = 1'b0;   // level shown while selected
    // load on select, phase zero shows the top bit at once
    always @(negedge sel_n_in) begin
        sh = tx_in;
        if (!pha_in) begin
            bq = sh[7];
            sh = sh << 1;
        end
    end
    // sample on the chosen edge, shift out on the other
    always @(sck_in) begin
        if (!sel_n_in) begin
            if ((sck_in != pol_in) ^ pha_in) begin
                rx_out = {rx_out[6:0], mosi_in};
            end else begin
                bq = sh[7];
                sh = sh << 1;
            end
        end
    end
    // released line shows the inverse of the last bit
    assign miso_out = sel_n_in ? ~bq : bq;
endmodule

// [testbench/spi_master_slave_port_tb_top.sv]
// self-checking bench for the serial port core
`timescale 1ns/100ps
module spi_master_slave_port_tb_top;
    logic       sys_clk_in = 1'b0;            // 25 MHz clock
    logic       rst_in = 1'b1;                // synchronous reset
    logic [2:0] clock_rate_select_in = 3'h0;  // master rate code
    logic [7:0] dr_wdata_in = 8'h00;          // byte to write
    logic       clock_polarity_in = 1'b0, clock_phase_in = 1'b0;
    logic       select_soft_manage_in = 1'b1, select_soft_level_in = 1'b1;
    logic       port_irq_enable_in = 1'b1, cpu_irq_mask_in = 1'b0;
    logic       csr_read_in = 1'b0, cr_write_in = 1'b0, dr_write_in = 1'b0, dr_read_in = 1'b0;
    logic       master_select_wr_in = 1'b0, port_enable_wr_in = 1'b0;
    logic       ss_n_in = 1'b1, tb_sck = 1'b0, tb_mosi = 1'b0, far_sel_n = 1'b1;
    logic [7:0] far_tx = 8'h00, dr_rdata_out, far_rx;
    logic       sck_out, sck_oe_out, mosi_out, mosi_oe_out, miso_out, miso_oe_out, far_miso;
    logic       transfer_done_flag_out, mode_fault_flag_out, write_collision_flag_out;
    logic       overrun_flag_out, master_select_out, port_enable_out, busy_out, irq_out;
    int         err_total = 0, total_checks = 0, seed = 49072;
    wire        sck_in = sck_oe_out ? sck_out : tb_sck;     // resolved clock line
    wire        mosi_in = mosi_oe_out ? mosi_out : tb_mosi; // resolved master out line
    wire        miso_in = miso_oe_out ? miso_out : far_miso; // resolved slave out line
    spi_master_slave_port dut (.*);
    spi_far_slave far (.sel_n_in(far_sel_n), .sck_in(sck_in), .mosi_in(mosi_in),
        .pol_in(clock_polarity_in), .pha_in(clock_phase_in), .tx_in(far_tx),
        .miso_out(far_miso), .rx_out(far_rx));
    always #20 sys_clk_in = ~sys_clk_in;
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic csr;
        @(posedge sys_clk_in) csr_read_in <= 1'b1;
        @(posedge sys_clk_in) csr_read_in <= 1'b0;
    endtask
    task automatic dwrite(input logic [7:0] d);
        @(posedge sys_clk_in);
        dr_wdata_in <= d;
        dr_write_in <= 1'b1;
        @(posedge sys_clk_in) dr_write_in <= 1'b0;
    endtask
    task automatic crw(input logic m, input logic e);
        @(posedge sys_clk_in);
        master_select_wr_in <= m;
        port_enable_wr_in <= e;
        cr_write_in <= 1'b1;
        @(posedge sys_clk_in) cr_write_in <= 1'b0;
    endtask
    // act as the far master for one slave byte
    task automatic slave_byte(input logic [7:0] m, output logic [7:0] got);
        for (int i = 7; i >= 0; i--) begin
            if (!clock_phase_in) tb_mosi <= m[i];
            cyc(8);
            if (!clock_phase_in) got[i] = miso_out;
            tb_sck <= ~clock_polarity_in;
            if (clock_phase_in) tb_mosi <= m[i];
            cyc(8);
            if (clock_phase_in) got[i] = miso_out;
            tb_sck <= clock_polarity_in;
        end
        cyc(8); // let the last edge land before select rises
    endtask
    function automatic logic exp_irq(input logic en, input logic msk);
        return en && !msk;
    endfunction
    task automatic summarize;
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        cyc(20000);
        err_total++;
        summarize();
    end
    initial begin
        logic [7:0] d, got, m0;
        time t0;
        int n;
        cyc(20);
        rst_in <= 1'b0;
        cyc(4);
        // master bytes over rate codes 0 to 5
        for (int i = 0; i < 6; i++) begin
            crw(1'b0, 1'b0);
            d = 8'($random(seed));
            far_tx <= 8'($random(seed));
            clock_rate_select_in <= 3'(i);
            {clock_polarity_in, tb_sck} <= {2{1'($random(seed))}}; // idle line matches polarity
            clock_phase_in <= 1'($random(seed));
            {port_irq_enable_in, cpu_irq_mask_in} <= 2'($random(seed));
            crw(1'b1, 1'b1);
            far_sel_n <= 1'b0;
            dwrite(d);
            t0 = $time;
            if (i == 0) begin
                cyc(8);
                dwrite(~d);
                cyc(1);
                chk("collision", 8'h01, write_collision_flag_out);
            end
            for (n = 0; n < 3000 && transfer_done_flag_out !== 1'b1; n++) cyc(1);
            n = int'(($time - t0) / 40);
            chk("rate", 8'h01, n >= (32 << i) && n <= (32 << i) + 10);
            chk("received", far_tx, dr_rdata_out);
            chk("far received", d, far_rx);
            chk("irq", exp_irq(port_irq_enable_in, cpu_irq_mask_in), irq_out);
            far_sel_n <= 1'b1;
            if (i == 1) begin
                dwrite(8'h5a);
                cyc(1);
                chk("busy", 8'h00, busy_out);
            end
            csr();
            dr_read_in <= 1'b1;
            cyc(1);
            dr_read_in <= 1'b0;
            cyc(1);
            chk("done", 8'h00, transfer_done_flag_out);
            chk("collision", 8'h00, write_collision_flag_out);
        end
        // fault from the soft level, then from the pin
        {port_irq_enable_in, cpu_irq_mask_in} <= 2'h2;
        for (int k = 0; k < 2; k++) begin
            crw(1'b1, 1'b1);
            select_soft_level_in <= k[0];
            select_soft_manage_in <= !k[0];
            ss_n_in <= !k[0];
            cyc(8);
            chk("fault", 8'h01, mode_fault_flag_out);
            chk("master", 8'h00, master_select_out);
            chk("irq", 8'h01, irq_out);
            select_soft_level_in <= 1'b1;
            ss_n_in <= 1'b1;
            cyc(6);
            crw(1'b1, 1'b1);
            cyc(1);
            chk("blocked", 8'h00, master_select_out);
            csr();
            crw(1'b1, 1'b1);
            cyc(1);
            chk("restored", 8'h01, master_select_out & !mode_fault_flag_out);
        end
        // slave mode: bench plays the far master
        crw(1'b0, 1'b0);
        select_soft_manage_in <= 1'b0;
        clock_polarity_in <= 1'($random(seed));
        clock_phase_in <= 1'($random(seed));
        cyc(1);
        tb_sck <= clock_polarity_in;
        crw(1'b0, 1'b1);
        d = 8'($random(seed));
        dwrite(d);
        for (int j = 0; j < 2; j++) begin
            ss_n_in <= 1'b0;
            cyc(8);
            m0 = (j == 0) ? 8'($random(seed)) : m0;
            slave_byte((j == 0) ? m0 : ~m0, got);
            ss_n_in <= 1'b1;
            cyc(20);
            if (j == 0) chk("slave out", d, got);
            chk("slave done", 8'h01, transfer_done_flag_out);
            chk("slave rx", m0, dr_rdata_out);
            chk("overrun", 8'(j), overrun_flag_out);
        end
        csr();
        dwrite(8'h00);
        cyc(1);
        chk("slave clear", 8'h00, transfer_done_flag_out | overrun_flag_out);
        summarize();
    end
endmodule
